// ---- verilog/dioc_pkg.sv ----
// Constants, types and register map of the digital I/O channel block.
// Assumes a single 200 MHz clock and a plain strobe-based register port.
package dioc_pkg;

    // ------------------------------------------------------------------
    // Sizes and clock
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int CW      = 26;
    localparam int NCH     = 8;
    localparam int AW      = 8;
    localparam int DW      = 32;

    // ------------------------------------------------------------------
    // Times in microseconds
    // ------------------------------------------------------------------
    localparam int INRUSH_T_US = 100000;
    localparam int DEB_T0_US   = 100;
    localparam int DEB_T1_US   = 1000;
    localparam int DEB_T2_US   = 10000;
    localparam int DEB_T3_US   = 20000;
    localparam int HOLD_T0_US  = 1000;
    localparam int HOLD_T1_US  = 15000;
    localparam int HOLD_T2_US  = 100000;
    localparam int HOLD_T3_US  = 200000;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [AW-1:0] ADDR_CFG      = 8'h00;
    localparam logic [AW-1:0] ADDR_OPEN_EN  = 8'h04;
    localparam logic [AW-1:0] ADDR_FAULT_ST = 8'h08;
    localparam logic [AW-1:0] ADDR_IDLE_ST  = 8'h0C;
    localparam logic [AW-1:0] ADDR_OUT_DATA = 8'h10;
    localparam logic [AW-1:0] ADDR_STATUS   = 8'h14;
    localparam logic [AW-1:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [AW-1:0] ADDR_IRQ_CLR  = 8'h1C;
    localparam logic [AW-1:0] ADDR_IRQ_EN   = 8'h20;

    // ------------------------------------------------------------------
    // Configuration fields and reset values
    // ------------------------------------------------------------------
    localparam int CFG_SUPPLY_SUP = 0;
    localparam int CFG_INRUSH_EN  = 1;
    localparam int CFG_DEB_LSB    = 2;
    localparam int CFG_HOLD_LSB   = 4;
    localparam int CFG_OUT_SUP    = 6;
    localparam int CFG_OUT_REC    = 7;
    localparam int CFG_HT_PRIO    = 8;
    localparam int CFG_W          = 9;
    localparam logic [CFG_W-1:0] CFG_RST = 9'h155;

    // Status fields
    localparam int ST_OPEN_LSB = 8;
    localparam int ST_SUPPLY   = 16;
    localparam int ST_OSHORT   = 17;
    localparam int ST_FAULT    = 18;
    localparam int ST_IDLE     = 19;
    localparam int ST_BLANK    = 20;

    // Interrupt bits
    localparam int IRQ_SUPPLY = 0;
    localparam int IRQ_OSHORT = 1;
    localparam int IRQ_OPEN   = 2;
    localparam int IRQ_W      = 3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OUTST_CLEAR = 2'h0,
        OUTST_HOLD  = 2'h1,
        OUTST_FORCE = 2'h2
    } dioc_outst_t;

    typedef enum logic [2:0] {
        LNK_RUN   = 3'h1,
        LNK_IDLE  = 3'h2,
        LNK_FAULT = 3'h4
    } dioc_link_t;

endpackage

// ---- verilog/dioc_in_chan.sv ----
// One input channel: three-stage synchroniser, debounce and pulse hold.
// Assumes debounce and hold counts stay steady while a change is pending.
`timescale 1ns/1ps
module dioc_in_chan
    import dioc_pkg::*;
(
    input  wire logic          sys_clk_i,
    input  wire logic          nrst_i,
    input  wire logic          pin_i,
    input  wire logic [CW-1:0] deb_cyc_i,
    input  wire logic [CW-1:0] hold_cyc_i,
    output logic               level_o
);

    logic          s1_r, s2_r, s3_r;
    logic          agree_r, agree_nxt;
    logic          acc_r, acc_nxt;
    logic [CW-1:0] deb_r, deb_nxt;
    logic [CW-1:0] hold_r, hold_nxt;
    logic          lvl_nxt;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        agree_nxt = (s2_r == s3_r) ? s3_r : agree_r;
        acc_nxt   = acc_r;
        deb_nxt   = '0;
        hold_nxt  = (hold_r != '0) ? hold_r - 1'b1 : '0;
        if (agree_r != acc_r) begin
            // Change must stay put for the whole window
            if (deb_r >= deb_cyc_i - 1'b1) begin
                acc_nxt = agree_r;
            end else begin
                deb_nxt = deb_r + 1'b1;
            end
        end
        if (acc_nxt && !acc_r) begin
            hold_nxt = hold_cyc_i - 1'b1;  // Stretch newly active input
        end
        lvl_nxt = acc_nxt | (hold_nxt != '0);
    end

    // Registers
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            agree_r <= 1'b0;
            acc_r   <= 1'b0;
            deb_r   <= '0;
            hold_r  <= '0;
            level_o <= 1'b0;
        end else begin
            s1_r    <= pin_i;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            agree_r <= agree_nxt;
            acc_r   <= acc_nxt;
            deb_r   <= deb_nxt;
            hold_r  <= hold_nxt;
            level_o <= lvl_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_accept_after_stable: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $changed(acc_r) |-> $past(deb_r) >= $past(deb_cyc_i) - 1'b1)
        else $error("input accepted before debounce time");

    a_hold_keeps_level: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        hold_r != '0 |-> level_o)
        else $error("held input dropped early");

endmodule

// ---- verilog/dioc_top.sv ----
// Digital I/O channel block: supervision, input filtering and output fallback.
// Assumes field pins are asynchronous and software uses the strobe port.
`timescale 1ns/1ps
module dioc_top
    import dioc_pkg::*;
#(
    parameter logic [CW-1:0] INRUSH_CYC = CW'(INRUSH_T_US * CLK_MHZ),
    parameter logic [CW-1:0] DEB_CYC0   = CW'(DEB_T0_US * CLK_MHZ),
    parameter logic [CW-1:0] DEB_CYC1   = CW'(DEB_T1_US * CLK_MHZ),
    parameter logic [CW-1:0] DEB_CYC2   = CW'(DEB_T2_US * CLK_MHZ),
    parameter logic [CW-1:0] DEB_CYC3   = CW'(DEB_T3_US * CLK_MHZ),
    parameter logic [CW-1:0] HOLD_CYC0  = CW'(HOLD_T0_US * CLK_MHZ),
    parameter logic [CW-1:0] HOLD_CYC1  = CW'(HOLD_T1_US * CLK_MHZ),
    parameter logic [CW-1:0] HOLD_CYC2  = CW'(HOLD_T2_US * CLK_MHZ),
    parameter logic [CW-1:0] HOLD_CYC3  = CW'(HOLD_T3_US * CLK_MHZ)
)
(
    input  wire logic           sys_clk_i,
    input  wire logic           nrst_i,
    input  wire logic [AW-1:0]  reg_addr_i,
    input  wire logic [DW-1:0]  reg_wdata_i,
    input  wire logic           reg_wr_i,
    input  wire logic           reg_rd_i,
    output logic      [DW-1:0]  reg_rdata_o,
    input  wire logic [NCH-1:0] din_i,
    input  wire logic           supply_short_i,
    input  wire logic           out_overcur_i,
    input  wire logic [NCH-1:0] open_wire_i,
    input  wire logic           comm_fault_i,
    input  wire logic           comm_idle_i,
    output logic      [NCH-1:0] din_filt_o,
    output logic      [NCH-1:0] dout_o,
    output logic                supply_err_o,
    output logic                out_short_err_o,
    output logic      [NCH-1:0] open_wire_err_o,
    output logic                irq_o
);

    localparam int SW = NCH + 4;

    // Channel fallback value for a given mode
    function automatic logic fallback(input logic [1:0] mode, input logic last);
        unique case (mode)
            OUTST_HOLD:  fallback = last;
            OUTST_FORCE: fallback = 1'b1;
            default:     fallback = 1'b0;
        endcase
    endfunction

    // Pick one of four counts by a 2-bit selector
    function automatic logic [CW-1:0] pick4(input logic [1:0] sel, input logic [CW-1:0] c0,
                                            input logic [CW-1:0] c1, input logic [CW-1:0] c2,
                                            input logic [CW-1:0] c3);
        unique case (sel)
            2'h0:    pick4 = c0;
            2'h1:    pick4 = c1;
            2'h2:    pick4 = c2;
            default: pick4 = c3;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [SW-1:0] p1_r, p2_r, p3_r, pin_r, pin_nxt;
    logic          sup_pin, ovc_pin, flt_pin, idl_pin;
    logic [NCH-1:0] ow_pin;

    // Value moves only once the last two stages agree
    always_comb begin
        pin_nxt = (p2_r & p3_r) | (pin_r & (p2_r ^ p3_r)) | (pin_r & ~p2_r & ~p3_r & '0);
        for (int i = 0; i < SW; i++) begin
            pin_nxt[i] = (p2_r[i] == p3_r[i]) ? p3_r[i] : pin_r[i];
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            p1_r  <= '0;
            p2_r  <= '0;
            p3_r  <= '0;
            pin_r <= '0;
        end else begin
            p1_r  <= {supply_short_i, out_overcur_i, comm_fault_i, comm_idle_i, open_wire_i};
            p2_r  <= p1_r;
            p3_r  <= p2_r;
            pin_r <= pin_nxt;
        end
    end

    assign {sup_pin, ovc_pin, flt_pin, idl_pin, ow_pin} = pin_r;

    // ------------------------------------------------------------------
    // Registers reached by software
    // ------------------------------------------------------------------
    logic [CFG_W-1:0]   cfg_r, cfg_nxt;
    logic [NCH-1:0]     open_en_r, open_en_nxt;
    logic [2*NCH-1:0]   fault_st_r, fault_st_nxt;
    logic [2*NCH-1:0]   idle_st_r, idle_st_nxt;
    logic [NCH-1:0]     out_data_r, out_data_nxt;
    logic [IRQ_W-1:0]   irq_en_r, irq_en_nxt;
    logic [IRQ_W-1:0]   irq_st_r, irq_st_nxt;
    logic [DW-1:0]      rdata_nxt;
    logic [IRQ_W-1:0]   irq_set;
    logic [DW-1:0]      status_word;
    logic               wr_clr;

    // Write decode, sticky flags and read mux
    always_comb begin
        cfg_nxt      = cfg_r;
        open_en_nxt  = open_en_r;
        fault_st_nxt = fault_st_r;
        idle_st_nxt  = idle_st_r;
        out_data_nxt = out_data_r;
        irq_en_nxt   = irq_en_r;
        wr_clr       = reg_wr_i && (reg_addr_i == ADDR_IRQ_CLR);
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                ADDR_CFG:      cfg_nxt      = reg_wdata_i[CFG_W-1:0];
                ADDR_OPEN_EN:  open_en_nxt  = reg_wdata_i[NCH-1:0];
                ADDR_FAULT_ST: fault_st_nxt = reg_wdata_i[2*NCH-1:0];
                ADDR_IDLE_ST:  idle_st_nxt  = reg_wdata_i[2*NCH-1:0];
                ADDR_OUT_DATA: out_data_nxt = reg_wdata_i[NCH-1:0];
                ADDR_IRQ_EN:   irq_en_nxt   = reg_wdata_i[IRQ_W-1:0];
                default:       cfg_nxt      = cfg_r;
            endcase
        end
        // Hardware set wins over a clear in the same cycle
        irq_st_nxt = (irq_st_r & ~(wr_clr ? reg_wdata_i[IRQ_W-1:0] : '0)) | irq_set;
        rdata_nxt  = '0;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADDR_CFG:      rdata_nxt = DW'(cfg_r);
                ADDR_OPEN_EN:  rdata_nxt = DW'(open_en_r);
                ADDR_FAULT_ST: rdata_nxt = DW'(fault_st_r);
                ADDR_IDLE_ST:  rdata_nxt = DW'(idle_st_r);
                ADDR_OUT_DATA: rdata_nxt = DW'(out_data_r);
                ADDR_STATUS:   rdata_nxt = status_word;
                ADDR_IRQ_STAT: rdata_nxt = DW'(irq_st_r);
                ADDR_IRQ_EN:   rdata_nxt = DW'(irq_en_r);
                default:       rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_r       <= CFG_RST;
            open_en_r   <= '0;
            fault_st_r  <= '0;
            idle_st_r   <= '0;
            out_data_r  <= '0;
            irq_en_r    <= '0;
            irq_st_r    <= '0;
            reg_rdata_o <= '0;
        end else begin
            cfg_r       <= cfg_nxt;
            open_en_r   <= open_en_nxt;
            fault_st_r  <= fault_st_nxt;
            idle_st_r   <= idle_st_nxt;
            out_data_r  <= out_data_nxt;
            irq_en_r    <= irq_en_nxt;
            irq_st_r    <= irq_st_nxt;
            reg_rdata_o <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Input channels
    // ------------------------------------------------------------------
    logic [CW-1:0] deb_cyc, hold_cyc;

    assign deb_cyc  = pick4(cfg_r[CFG_DEB_LSB +: 2], DEB_CYC0, DEB_CYC1, DEB_CYC2, DEB_CYC3);
    assign hold_cyc = pick4(cfg_r[CFG_HOLD_LSB +: 2], HOLD_CYC0, HOLD_CYC1, HOLD_CYC2, HOLD_CYC3);

    for (genvar g = 0; g < NCH; g++) begin : g_in
        dioc_in_chan u_chan (
            .sys_clk_i  (sys_clk_i),
            .nrst_i     (nrst_i),
            .pin_i      (din_i[g]),
            .deb_cyc_i  (deb_cyc),
            .hold_cyc_i (hold_cyc),
            .level_o    (din_filt_o[g])
        );
    end

    // ------------------------------------------------------------------
    // Link state and output fallback
    // ------------------------------------------------------------------
    dioc_link_t     lnk_r, lnk_nxt;
    logic [NCH-1:0] dout_nxt;

    // Fault outranks idle; priority bit gates the per-channel settings
    always_comb begin
        lnk_nxt  = flt_pin ? LNK_FAULT : (idl_pin ? LNK_IDLE : LNK_RUN);
        dout_nxt = out_data_r;
        unique case (lnk_r)
            LNK_RUN: dout_nxt = out_data_r;
            LNK_FAULT: begin
                for (int i = 0; i < NCH; i++) begin
                    dout_nxt[i] = cfg_r[CFG_HT_PRIO] ? fallback(fault_st_r[2*i +: 2], dout_o[i])
                                                     : 1'b0;
                end
            end
            LNK_IDLE: begin
                for (int i = 0; i < NCH; i++) begin
                    dout_nxt[i] = cfg_r[CFG_HT_PRIO] ? fallback(idle_st_r[2*i +: 2], dout_o[i])
                                                     : 1'b0;
                end
            end
            default: dout_nxt = '0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lnk_r  <= LNK_RUN;
            dout_o <= '0;
        end else begin
            lnk_r  <= lnk_nxt;
            dout_o <= dout_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Supervision and interrupts
    // ------------------------------------------------------------------
    logic [CW-1:0]  blank_r, blank_nxt;
    logic           sup_err_nxt, osh_err_nxt, ovc_seen, irq_nxt;
    logic [NCH-1:0] ow_err_nxt;

    always_comb begin
        // Any output turning on starts the blanking window
        blank_nxt = (blank_r != '0) ? blank_r - 1'b1 : '0;
        if (cfg_r[CFG_INRUSH_EN] && |(dout_nxt & ~dout_o)) begin
            blank_nxt = INRUSH_CYC - 1'b1;
        end
        ovc_seen    = ovc_pin && (blank_r == '0);
        sup_err_nxt = cfg_r[CFG_SUPPLY_SUP] && sup_pin;
        ow_err_nxt  = open_en_r & ow_pin;
        if (!cfg_r[CFG_OUT_SUP]) begin
            osh_err_nxt = 1'b0;
        end else if (ovc_seen) begin
            osh_err_nxt = 1'b1;
        end else begin
            osh_err_nxt = cfg_r[CFG_OUT_REC] ? out_short_err_o : 1'b0;
        end
        irq_set = {(|ow_err_nxt) & ~(|open_wire_err_o), osh_err_nxt & ~out_short_err_o,
                   sup_err_nxt & ~supply_err_o};
        irq_nxt = |(irq_st_nxt & irq_en_nxt);
        status_word = DW'({blank_r != '0, lnk_r == LNK_IDLE, lnk_r == LNK_FAULT, out_short_err_o,
                           supply_err_o, open_wire_err_o, din_filt_o});
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            blank_r         <= '0;
            supply_err_o    <= 1'b0;
            out_short_err_o <= 1'b0;
            open_wire_err_o <= '0;
            irq_o           <= 1'b0;
        end else begin
            blank_r         <= blank_nxt;
            supply_err_o    <= sup_err_nxt;
            out_short_err_o <= osh_err_nxt;
            open_wire_err_o <= ow_err_nxt;
            irq_o           <= irq_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    a_supply_err_gate: assert property (supply_err_o |-> $past(cfg_r[CFG_SUPPLY_SUP]) && $past(sup_pin))
        else $error("supply error without enabled short");
    a_blank_masks_ovc: assert property (
        blank_r != '0 && !out_short_err_o && ovc_pin |=> !out_short_err_o || $past(ovc_seen))
        else $error("overcurrent seen inside blanking");
    a_oshort_raise: assert property (
        cfg_r[CFG_OUT_SUP] && ovc_pin && blank_r == '0 ##1 cfg_r[CFG_OUT_SUP] |-> out_short_err_o)
        else $error("output short not raised");
    a_oshort_off: assert property (!cfg_r[CFG_OUT_SUP] |=> !out_short_err_o)
        else $error("output short raised while disabled");
    a_auto_clear: assert property (
        cfg_r[CFG_OUT_SUP] && !cfg_r[CFG_OUT_REC] && !ovc_pin [*2] |-> ##1 !out_short_err_o)
        else $error("auto recovery did not clear");
    a_manual_latch: assert property (
        out_short_err_o && cfg_r[CFG_OUT_SUP] && cfg_r[CFG_OUT_REC] |=> out_short_err_o)
        else $error("manual error cleared early");
    a_open_wire: assert property (open_wire_err_o == $past(open_en_r & ow_pin) || $rose(nrst_i))
        else $error("open wire error mismatch");
    a_fault_force: assert property (
        lnk_r == LNK_FAULT && cfg_r[CFG_HT_PRIO] && fault_st_r[1:0] == OUTST_FORCE |=> dout_o[0])
        else $error("forced output not on in fault");
    a_idle_clear: assert property (
        lnk_r == LNK_IDLE && cfg_r[CFG_HT_PRIO] && idle_st_r[1:0] == OUTST_CLEAR |=> !dout_o[0])
        else $error("cleared output still on in idle");
    a_prio_gate: assert property (
        lnk_r != LNK_RUN && !cfg_r[CFG_HT_PRIO] |=> dout_o == '0)
        else $error("fallback used without terminal priority");
    a_irq_level: assert property (irq_o == |$past(irq_st_nxt & irq_en_nxt) || $rose(nrst_i))
        else $error("interrupt level wrong");

    c_fault_hold: cover property (lnk_r == LNK_FAULT && fault_st_r[1:0] == OUTST_HOLD ##1 dout_o[0]);
    c_idle_entry: cover property (lnk_r == LNK_RUN ##1 lnk_r == LNK_IDLE);
    c_manual_kept: cover property (out_short_err_o && cfg_r[CFG_OUT_REC] && !ovc_pin [*3]);
    c_irq_fire: cover property ($rose(irq_o));

endmodule

// ---- tb/dioc_load_model.sv ----
// Field load model: excess current and broken wire seen by the outputs.
// Assumes the bench selects a shorted load and the broken channels.
`timescale 1ns/1ps
module dioc_load_model
    import dioc_pkg::*;
(
    input  wire logic [NCH-1:0] dout_i,
    input  wire logic           short_en_i,
    input  wire logic [NCH-1:0] open_mask_i,
    output logic                overcur_o,
    output logic      [NCH-1:0] open_wire_o
);
    // A shorted load draws current only while some channel drives it
    assign overcur_o   = short_en_i & (|dout_i);
    // Broken wires stay broken whether driven or not
    assign open_wire_o = open_mask_i;
endmodule

// ---- tb/dioc_top_tb.sv ----
// Bench of the digital I/O channel block with short counts.
// Assumes the load model on the outputs and the strobe register port.
`timescale 1ns/1ps
module dioc_top_tb
    import dioc_pkg::*;
;
    typedef struct packed {
        logic [8:0]  cfg;
        logic [15:0] fst;
        logic [15:0] ist;
        logic [7:0]  od;
        logic        f;
        logic        i;
        logic [7:0]  exp;
    } dioc_row_t;
    // Link state rows: cfg, fault states, idle states, out data, fault, idle, expected drive
    localparam dioc_row_t ROWS [11] = '{
        '{9'h155, 16'h0000, 16'h0000, 8'hFF, 1'b1, 1'b0, 8'h00},
        '{9'h155, 16'hAAAA, 16'h0000, 8'h00, 1'b1, 1'b0, 8'hFF},
        '{9'h155, 16'h5555, 16'h0000, 8'hA5, 1'b1, 1'b0, 8'hA5},
        '{9'h155, 16'h0009, 16'h0000, 8'h01, 1'b1, 1'b0, 8'h03},
        '{9'h155, 16'hFFFF, 16'h0000, 8'hFF, 1'b1, 1'b0, 8'h00},
        '{9'h155, 16'h0000, 16'hAAAA, 8'h00, 1'b0, 1'b1, 8'hFF},
        '{9'h155, 16'h0000, 16'h5555, 8'h3C, 1'b0, 1'b1, 8'h3C},
        '{9'h155, 16'h0000, 16'hAAAA, 8'h00, 1'b1, 1'b1, 8'h00},
        '{9'h055, 16'hAAAA, 16'h0000, 8'hFF, 1'b1, 1'b0, 8'h00},
        '{9'h155, 16'h0000, 16'h0000, 8'hFF, 1'b0, 1'b1, 8'h00},
        '{9'h155, 16'h0000, 16'h0000, 8'h5A, 1'b0, 1'b0, 8'h5A}};
    logic           sys_clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, sup = 1'b0;
    logic           fault = 1'b0, idle = 1'b0, shrt = 1'b0, oc, serr, oserr, irq;
    logic [AW-1:0]  addr = '0;
    logic [DW-1:0]  wdata = '0, rdata;
    logic [NCH-1:0] din = '0, omask = '0, filt, dout, owerr, ow;
    int             errors = 0, num_checks = 0;
    dioc_row_t      r;

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    dioc_top #(.INRUSH_CYC(CW'(40)), .DEB_CYC0(CW'(20)), .DEB_CYC1(CW'(30)), .DEB_CYC2(CW'(40)),
        .DEB_CYC3(CW'(50)), .HOLD_CYC0(CW'(60)), .HOLD_CYC1(CW'(80)), .HOLD_CYC2(CW'(100)),
        .HOLD_CYC3(CW'(120))) dut_u (.sys_clk_i(sys_clk), .nrst_i(nrst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .din_i(din),
        .supply_short_i(sup), .out_overcur_i(oc), .open_wire_i(ow), .comm_fault_i(fault),
        .comm_idle_i(idle), .din_filt_o(filt), .dout_o(dout), .supply_err_o(serr),
        .out_short_err_o(oserr), .open_wire_err_o(owerr), .irq_o(irq));
    dioc_load_model load_u (.dout_i(dout), .short_en_i(shrt), .open_mask_i(omask),
        .overcur_o(oc), .open_wire_o(ow));

    // Shared compare, bus cycles and run control
    task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge sys_clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge sys_clk);
        addr <= a; rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(posedge sys_clk);
        chk(rdata, e);
    endtask
    task automatic rst;
        nrst <= 1'b0;
        cyc(5);
        nrst <= 1'b1;
        cyc(2);
    endtask
    task automatic end_of_test;
        $display("errors=%0d num_checks=%0d", errors, num_checks);
        if (errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #200000;
        errors++;
        end_of_test();
    end

    // Main sequence
    initial begin
        rst();
        rchk(ADDR_CFG, 32'h0000_0155);
        rchk(ADDR_STATUS, 32'h0000_0000);
        rchk(8'h30, 32'h0000_0000);
        foreach (ROWS[k]) begin
            r = ROWS[k];
            fault <= 1'b0; idle <= 1'b0;
            wreg(ADDR_CFG, DW'(r.cfg)); wreg(ADDR_FAULT_ST, DW'(r.fst));
            wreg(ADDR_IDLE_ST, DW'(r.ist)); wreg(ADDR_OUT_DATA, DW'(r.od));
            cyc(10);
            fault <= r.f; idle <= r.i;
            cyc(20);
            chk(DW'(dout), DW'(r.exp));
        end
        fault <= 1'b0;
        wreg(ADDR_CFG, 32'h0000_0155);
        // Supply short with supervision on, then interrupt raise, mask and clear
        sup <= 1'b1; cyc(10);
        chk(DW'(serr), 32'h1);
        rchk(ADDR_IRQ_STAT, 32'h1);
        chk(DW'(irq), 32'h0);
        wreg(ADDR_IRQ_EN, 32'h7); cyc(3);
        chk(DW'(irq), 32'h1);
        sup <= 1'b0; wreg(ADDR_IRQ_CLR, 32'h1); cyc(10);
        chk(DW'(irq), 32'h0);
        wreg(ADDR_CFG, 32'h0000_0154); sup <= 1'b1; cyc(10);
        chk(DW'(serr), 32'h0);
        sup <= 1'b0;
        // Output short, automatic recovery, then disabled supervision
        wreg(ADDR_CFG, 32'h0000_0155); shrt <= 1'b1; cyc(10);
        chk(DW'(oserr), 32'h1);
        shrt <= 1'b0; cyc(10);
        chk(DW'(oserr), 32'h0);
        wreg(ADDR_CFG, 32'h0000_0115); shrt <= 1'b1; cyc(10);
        chk(DW'(oserr), 32'h0);
        // Manual recovery latches until reset
        wreg(ADDR_CFG, 32'h0000_01D5); cyc(10);
        shrt <= 1'b0; cyc(10);
        chk(DW'(oserr), 32'h1);
        rst();
        chk(DW'(oserr), 32'h0);
        // Inrush blanking hides the short for the blanking count only
        wreg(ADDR_CFG, 32'h0000_0157); shrt <= 1'b1; wreg(ADDR_OUT_DATA, 32'hFF); cyc(10);
        chk(DW'(oserr), 32'h0);
        cyc(60);
        chk(DW'(oserr), 32'h1);
        shrt <= 1'b0; wreg(ADDR_CFG, 32'h0000_0155);
        // Open wire detection per channel
        omask <= 8'hFF; cyc(10);
        chk(DW'(owerr), 32'h0);
        wreg(ADDR_OPEN_EN, 32'h0F); cyc(10);
        chk(DW'(owerr), 32'h0F);
        omask <= 8'h00;
        // Short glitch rejected, long pulse accepted and stretched
        din <= 8'h01; cyc(10); din <= 8'h00; cyc(50);
        chk(DW'(filt), 32'h0);
        din <= 8'h81; cyc(60); din <= 8'h00;
        chk(DW'(filt), 32'h81);
        cyc(40);
        chk(DW'(filt), 32'h81);
        cyc(120);
        chk(DW'(filt), 32'h0);
        // Other filter and hold selections: shortest passes 25, longest rejects 40, third holds 100
        wreg(ADDR_CFG, 32'h0000_0141); din <= 8'h02; cyc(25); din <= 8'h00; cyc(30);
        chk(DW'(filt), 32'h02);
        cyc(40);
        chk(DW'(filt), 32'h0);
        wreg(ADDR_CFG, 32'h0000_017D); din <= 8'h02; cyc(40); din <= 8'h00; cyc(60);
        chk(DW'(filt), 32'h0);
        wreg(ADDR_CFG, 32'h0000_0169); din <= 8'h02; cyc(45); din <= 8'h00; cyc(85);
        chk(DW'(filt), 32'h02);
        end_of_test();
    end
endmodule
